// ==== verilog/ccie_pkg.sv ====
/*
  Shared constants for the clear/call execution unit: opcode patterns,
  quarter-phase encoding, widths and reset values.
  Assumes a 14-bit instruction word and a 13-bit program counter.
*/
package ccie_pkg;
  // Widths
  localparam int CCIE_IW = 14; // Instruction word width
  localparam int CCIE_PCW = 13; // Program counter width
  localparam int CCIE_FW = 7; // File address width
  localparam int CCIE_KW = 11; // Call immediate width
  localparam int CCIE_WDW = 8; // Watchdog counter width
  localparam int CCIE_PSW = 8; // Watchdog prescaler width

  // Quarter phases, Gray order along the cycle
  typedef enum logic [1:0] {
    CCIE_Q1 = 2'h0,
    CCIE_Q2 = 2'h1,
    CCIE_Q3 = 2'h3,
    CCIE_Q4 = 2'h2
  } ccie_phase_t;

  // Decoded operation of the current cycle
  typedef enum logic [2:0] {
    CCIE_OP_NOP = 3'h0,
    CCIE_OP_BTSC = 3'h1,
    CCIE_OP_CALL = 3'h2,
    CCIE_OP_CLEAR_FILE_REG_OP = 3'h3,
    CCIE_OP_CLEAR_WORK_REG_OP = 3'h4,
    CCIE_OP_CLEAR_WATCHDOG_OP = 3'h5,
    CCIE_OP_OTHER = 3'h6
  } ccie_op_t;

  // Opcode patterns
  localparam logic [13:0] CCIE_BTSC_MASK = 14'h3c00;
  localparam logic [13:0] CCIE_BTSC_VAL = 14'h1800;
  localparam logic [13:0] CCIE_CALL_MASK = 14'h3800;
  localparam logic [13:0] CCIE_CALL_VAL = 14'h2000;
  localparam logic [13:0] CCIE_CLEAR_FILE_REG_OP_MASK = 14'h3f80;
  localparam logic [13:0] CCIE_CLEAR_FILE_REG_OP_VAL = 14'h0180;
  localparam logic [13:0] CCIE_CLEAR_WORK_REG_OP_VAL = 14'h0100;
  localparam logic [13:0] CCIE_CLEAR_WATCHDOG_OP_VAL = 14'h0064;

  // Field positions
  localparam int CCIE_BIT_LSB = 7; // Bit-select field low bit
  localparam int CCIE_LATCH_LSB = 3; // High latch bits used for call

  // Reset values
  localparam logic [CCIE_PCW-1:0] CCIE_PC_RST = 13'h0000;
  localparam logic [7:0] CCIE_ZERO8 = 8'h00;
endpackage

// ==== verilog/ccie_file_if.sv ====
/*
  Carrier between the decoder and the phase sequencer: decoded
  operation plus its operand fields.
  Assumes both ends share clock_i.
*/
`timescale 1ns/1ps
interface ccie_file_if;
  import ccie_pkg::*;
  ccie_op_t op; // Decoded operation
  logic [CCIE_FW-1:0] faddr; // File register address
  logic [2:0] bitsel; // Bit under test
  logic [CCIE_KW-1:0] imm; // Call target low bits
  modport dec (output op, output faddr, output bitsel, output imm);
  modport seq (input op, input faddr, input bitsel, input imm);
endinterface

// ==== verilog/ccie_decode.sv ====
/*
  Combinational decode of the fetched instruction word into the
  operations handled by this unit.
  Assumes the word is stable from the start of phase one.
*/
`timescale 1ns/1ps
module ccie_decode
  import ccie_pkg::*;
(
  input wire logic [CCIE_IW-1:0] instr_i,
  ccie_file_if.dec dec
);
  // Match a word against a masked pattern
  function automatic logic match(input logic [13:0] w,
                                 input logic [13:0] m,
                                 input logic [13:0] v);
    match = (w & m) == v;
  endfunction

  // Pick the operation; clear-work ignores its low seven bits
  always_comb begin
    if (match(instr_i, CCIE_BTSC_MASK, CCIE_BTSC_VAL)) begin
      dec.op = CCIE_OP_BTSC;
    end else if (match(instr_i, CCIE_CALL_MASK, CCIE_CALL_VAL)) begin
      dec.op = CCIE_OP_CALL;
    end else if (match(instr_i, CCIE_CLEAR_FILE_REG_OP_MASK, CCIE_CLEAR_FILE_REG_OP_VAL)) begin
      dec.op = CCIE_OP_CLEAR_FILE_REG_OP;
    end else if (match(instr_i, CCIE_CLEAR_FILE_REG_OP_MASK, CCIE_CLEAR_WORK_REG_OP_VAL)) begin
      dec.op = CCIE_OP_CLEAR_WORK_REG_OP;
    end else if (instr_i == CCIE_CLEAR_WATCHDOG_OP_VAL) begin
      dec.op = CCIE_OP_CLEAR_WATCHDOG_OP;
    end else begin
      dec.op = CCIE_OP_OTHER;
    end
  end

  // Operand fields
  assign dec.faddr = instr_i[CCIE_FW-1:0];
  assign dec.bitsel = instr_i[CCIE_BIT_LSB+2:CCIE_BIT_LSB];
  assign dec.imm = instr_i[CCIE_KW-1:0];
endmodule

// ==== verilog/ccie_exec.sv ====
/*
  Quarter-phase execution unit for bit-test-skip-if-clear, call,
  clear-file, clear-work and clear-watchdog.
  Assumes clock_i is the quarter-phase clock, each rising edge one phase, and
  that the fetch path holds instr_i for a whole instruction cycle.
  File read data arrives in the same phase as file_rd_o.
*/
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
module ccie_exec
  import ccie_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [CCIE_IW-1:0] instr_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [4:0] pc_high_latch_i,
  input wire logic wdt_tick_i,
  output logic [1:0] phase_o,
  output logic cycle_end_o,
  output logic flush_o,
  output logic file_rd_o,
  output logic file_wr_o,
  output logic [CCIE_FW-1:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  output logic [7:0] work_reg_o,
  output logic zero_flag_o,
  output logic [CCIE_PCW-1:0] pc_o,
  output logic stack_push_o,
  output logic [CCIE_PCW-1:0] stack_top_o,
  output logic [CCIE_WDW-1:0] wdt_count_o,
  output logic [CCIE_PSW-1:0] wdt_prescale_o,
  output logic timeout_flag_o,
  output logic powerdown_flag_o
);
  ccie_file_if dif (); // Decoded fields

  ccie_decode u_dec (
    .instr_i(instr_i),
    .dec(dif.dec)
  );

  ccie_phase_t phase_q; // Current quarter phase
  logic nop_cycle_q; // Current cycle is a forced no-operation
  ccie_op_t op_q; // Operation latched in Q1
  logic [CCIE_FW-1:0] faddr_q; // Latched file address
  logic [2:0] bitsel_q; // Latched bit select
  logic [CCIE_KW-1:0] imm_q; // Latched call target
  logic [7:0] rdata_q; // File data captured at the end of Q2
  logic skip_q; // Tested bit was clear
  logic [CCIE_PCW-1:0] pc_q; // Program counter
  logic [7:0] work_q; // Working register
  logic zero_q; // Zero flag
  logic [CCIE_WDW-1:0] wdt_q; // Watchdog counter
  logic [CCIE_PSW-1:0] pre_q; // Watchdog prescaler
  logic to_q; // Time-out flag (active-low sense kept as stored)
  logic pd_q; // Power-down flag
  logic rd_q; // File read strobe
  logic wr_q; // File write strobe
  logic push_q; // Stack push strobe
  logic [CCIE_PCW-1:0] tos_q; // Pushed return address
  logic end_q; // Last phase marker

  // Return address: counter plus one, kept at counter width
  function automatic logic [CCIE_PCW-1:0] pc_inc(
    input logic [CCIE_PCW-1:0] pc);
    pc_inc = CCIE_PCW'(pc + 1'b1);
  endfunction

  // Phase sequencer, Q1 to Q4 then around
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      phase_q <= CCIE_Q1;
    end else begin
      case (phase_q)
        CCIE_Q1: phase_q <= CCIE_Q2;
        CCIE_Q2: phase_q <= CCIE_Q3;
        CCIE_Q3: phase_q <= CCIE_Q4;
        CCIE_Q4: phase_q <= CCIE_Q1;
        default: phase_q <= CCIE_Q1;
      endcase
    end
  end

  // Decode captured in Q1; a forced no-operation cycle latches CCIE_OP_NOP, though its operand fields are still latched
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      op_q <= CCIE_OP_NOP;
      faddr_q <= '0;
      bitsel_q <= '0;
      imm_q <= '0;
    end else if (phase_q == CCIE_Q1) begin
      op_q <= nop_cycle_q ? CCIE_OP_NOP : dif.op;
      faddr_q <= dif.faddr;
      bitsel_q <= dif.bitsel;
      imm_q <= dif.imm;
    end
  end

  // Two-cycle operations force the following cycle to no-operation
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      nop_cycle_q <= 1'b0;
    end else if (phase_q == CCIE_Q4) begin
      if (op_q == CCIE_OP_CALL) begin
        nop_cycle_q <= 1'b1;
      end else if (op_q == CCIE_OP_BTSC && skip_q) begin
        nop_cycle_q <= 1'b1;
      end else begin
        nop_cycle_q <= 1'b0;
      end
    end
  end

  // File read strobe in Q2, data captured at the end of Q2
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rd_q <= 1'b0;
      rdata_q <= CCIE_ZERO8;
    end else begin
      // Raised for Q2 of bit test and clear file; clear work reads nothing
      rd_q <= (phase_q == CCIE_Q1) && !nop_cycle_q &&
              (dif.op == CCIE_OP_BTSC || dif.op == CCIE_OP_CLEAR_FILE_REG_OP);
      if (phase_q == CCIE_Q2) begin
        rdata_q <= file_rdata_i;
      end
    end
  end

  // Bit evaluation in Q3, no write-back for the bit test
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      skip_q <= 1'b0;
    end else if (phase_q == CCIE_Q3) begin
      skip_q <= (op_q == CCIE_OP_BTSC) && !rdata_q[bitsel_q];
    end
  end

  // File write strobe in Q4 with zero data
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= (phase_q == CCIE_Q3) && (op_q == CCIE_OP_CLEAR_FILE_REG_OP);
    end
  end

  // Working register and zero flag written at the end of Q4
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      work_q <= CCIE_ZERO8;
      zero_q <= 1'b0;
    end else if (phase_q == CCIE_Q4) begin
      if (op_q == CCIE_OP_CLEAR_WORK_REG_OP) begin
        work_q <= CCIE_ZERO8;
        zero_q <= 1'b1;
      end else if (op_q == CCIE_OP_CLEAR_FILE_REG_OP) begin
        zero_q <= 1'b1;
      end
    end
  end

  // Program counter and return stack; call writes PC in Q4
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pc_q <= CCIE_PC_RST;
      tos_q <= CCIE_PC_RST;
      push_q <= 1'b0;
    end else begin
      push_q <= (phase_q == CCIE_Q3) && (op_q == CCIE_OP_CALL);
      if (phase_q == CCIE_Q4) begin
        if (op_q == CCIE_OP_CALL) begin
          tos_q <= pc_inc(pc_q);
          pc_q <= {pc_high_latch_i[CCIE_LATCH_LSB+1:CCIE_LATCH_LSB],
                   imm_q};
        end else begin
          // Plain advance, also over each discarded fetch
          pc_q <= pc_inc(pc_q);
        end
      end
    end
  end

  // Watchdog counter, prescaler and status flags
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wdt_q <= '0;
      pre_q <= '0;
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (phase_q == CCIE_Q4 && op_q == CCIE_OP_CLEAR_WATCHDOG_OP) begin
      // Clear wins over a tick landing in the same phase
      wdt_q <= '0;
      pre_q <= '0;
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (wdt_tick_i) begin
      pre_q <= CCIE_PSW'(pre_q + 1'b1);
      if (&pre_q) begin
        wdt_q <= CCIE_WDW'(wdt_q + 1'b1);
        if (&wdt_q) begin
          to_q <= 1'b0; // Time-out reported, sticky until cleared
        end
      end
    end
  end

  // Cycle marker for the fetch path; the flush marker is the no-op flop
  // itself, so it covers all four phases of the discarded cycle
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      end_q <= 1'b0;
    end else begin
      end_q <= (phase_q == CCIE_Q3);
    end
  end

  assign phase_o = phase_q;
  assign cycle_end_o = end_q;
  assign flush_o = nop_cycle_q;
  assign file_rd_o = rd_q;
  assign file_wr_o = wr_q;
  assign file_addr_o = faddr_q;
  assign file_wdata_o = CCIE_ZERO8;
  assign work_reg_o = work_q;
  assign zero_flag_o = zero_q;
  assign pc_o = pc_q;
  assign stack_push_o = push_q;
  assign stack_top_o = tos_q;
  assign wdt_count_o = wdt_q;
  assign wdt_prescale_o = pre_q;
  assign timeout_flag_o = to_q;
  assign powerdown_flag_o = pd_q;
endmodule

// ==== tb/ccie_file_model.sv ====
/*
  Data register file seen from the unit: answers reads, takes writes.
  Assumes read strobe, address and write strobe come from the unit.
*/
`timescale 1ns/1ps
module ccie_file_model
  import ccie_pkg::*;
(
  input wire logic clock_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [CCIE_FW-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  // Storage; the bench presets cells directly, so no always_ff here
  logic [7:0] mem_q [0:127];
  // Last value read, kept only to spoil the idle bus
  logic [7:0] last_q = 8'h00;
  // Write lands at the edge that ends the write phase
  always @(posedge clock_i) begin
    if (wr_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    if (rd_i) begin
      last_q <= mem_q[addr_i];
    end
  end
  // Idle bus shows the inverse, so a late sample reads wrong data
  assign rdata_o = rd_i ? mem_q[addr_i] : ~last_q;
endmodule

// ==== tb/ccie_exec_checker.sv ====
/*
  Port assertions for the clear/call unit.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module ccie_exec_checker
  import ccie_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [CCIE_IW-1:0] instr_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic [4:0] pc_high_latch_i,
  input wire logic [1:0] phase_o,
  input wire logic flush_o,
  input wire logic file_rd_o,
  input wire logic file_wr_o,
  input wire logic [7:0] work_reg_o,
  input wire logic zero_flag_o,
  input wire logic [CCIE_PCW-1:0] pc_o,
  input wire logic stack_push_o,
  input wire logic [CCIE_PCW-1:0] stack_top_o,
  input wire logic [CCIE_WDW-1:0] wdt_count_o,
  input wire logic timeout_flag_o
);
  // Tested bit, caught while read data stands
  logic bit_q;
  always_ff @(posedge clock_i) begin
    if (phase_o == 2'h1) begin
      bit_q <= file_rdata_i[instr_i[9:7]];
    end
  end
  // Call target and return address
  wire logic [CCIE_PCW-1:0] tgt = {pc_high_latch_i[4:3], instr_i[10:0]};
  wire logic [CCIE_PCW-1:0] ret = pc_o + 13'h0001;
  // Last phase of a cycle that really executes
  wire logic q4 = phase_o == 2'h2 && !flush_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence phase_walk;
    phase_o == 2'h1 ##1 phase_o == 2'h3 ##1 phase_o == 2'h2;
  endsequence
  sequence dead_cycle;
    flush_o [*4];
  endsequence
  chk_phase_walk: assert property (
    phase_o == 2'h0 |=> phase_walk) else $error("phase order broken");
  chk_read_q2: assert property (
    file_rd_o |-> phase_o == 2'h1 &&
    (instr_i & CCIE_CLEAR_FILE_REG_OP_MASK) != CCIE_CLEAR_WORK_REG_OP_VAL) else $error("bad read");
  chk_write_q4: assert property (
    file_wr_o |-> phase_o == 2'h2 && $past(file_rd_o, 2) ##1 zero_flag_o)
    else $error("bad file write");
  chk_call_load: assert property (
    stack_push_o |-> phase_o == 2'h2 ##1
    pc_o == $past(tgt) && stack_top_o == $past(ret)) else $error("bad call");
  chk_call_dead: assert property (
    stack_push_o |=> dead_cycle) else $error("call not followed by no-op");
  chk_skip_bit: assert property (
    q4 && (instr_i & CCIE_BTSC_MASK) == CCIE_BTSC_VAL |->
    !file_wr_o ##1 flush_o == !$past(bit_q)) else $error("bad skip");
  chk_clear_work_reg_op_zero: assert property (
    q4 && (instr_i & CCIE_CLEAR_FILE_REG_OP_MASK) == CCIE_CLEAR_WORK_REG_OP_VAL |=>
    work_reg_o == 8'h00 && zero_flag_o) else $error("work not cleared");
  chk_wdt_clear: assert property (
    q4 && instr_i == CCIE_CLEAR_WATCHDOG_OP_VAL |=> wdt_count_o == 8'h00 &&
    timeout_flag_o) else $error("watchdog not cleared");
endmodule

bind ccie_exec ccie_exec_checker u_chk (.clock_i(clock_i),
  .resetn_i(resetn_i), .instr_i(instr_i), .file_rdata_i(file_rdata_i),
  .pc_high_latch_i(pc_high_latch_i), .phase_o(phase_o), .flush_o(flush_o),
  .file_rd_o(file_rd_o), .file_wr_o(file_wr_o), .work_reg_o(work_reg_o),
  .zero_flag_o(zero_flag_o), .pc_o(pc_o), .stack_push_o(stack_push_o),
  .stack_top_o(stack_top_o), .wdt_count_o(wdt_count_o),
  .timeout_flag_o(timeout_flag_o));

// ==== tb/tb_top.sv ====
/*
  Self-checking bench: random mix of the five operations.
  Assumes synchronous active-low reset and the file model beside it.
*/
`timescale 1ns/1ps
module tb_top;
  import ccie_pkg::*;
  logic clock_i = 0;
  logic resetn_i = 0;
  logic [13:0] instr_i = 14'h0000;
  logic [4:0] lat = 5'h00;
  logic tick = 0;
  logic [7:0] rdata, wdata, work, wdt, pre, fd, qd;
  logic [6:0] fadr, fa, qa;
  logic [2:0] fb, qb;
  logic zero, flush, rd, wr, tof, pdf;
  logic [12:0] pc, stack_top, pt, ptos;
  logic [12:0] epc = 13'h0000;
  logic [13:0] w;
  logic [31:0] lf = 32'h043b;
  logic fl = 0;
  int k, pk = 0, cyc = 0, n_fail = 0, comparisons = 0;
  ccie_exec dut (.clock_i(clock_i), .resetn_i(resetn_i), .instr_i(instr_i),
    .file_rdata_i(rdata), .pc_high_latch_i(lat), .wdt_tick_i(tick),
    .phase_o(), .cycle_end_o(), .flush_o(flush), .file_rd_o(rd),
    .file_wr_o(wr), .file_addr_o(fadr), .file_wdata_o(wdata),
    .work_reg_o(work), .zero_flag_o(zero), .pc_o(pc), .stack_push_o(),
    .stack_top_o(stack_top), .wdt_count_o(wdt), .wdt_prescale_o(pre),
    .timeout_flag_o(tof), .powerdown_flag_o(pdf));
  ccie_file_model mem (.clock_i(clock_i), .rd_i(rd), .wr_i(wr),
    .addr_i(fadr), .wdata_i(wdata), .rdata_o(rdata));
  // Random source
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Call target: latch bits above the immediate
  function automatic logic [12:0] call_pc(input logic [4:0] l,
                                          input logic [13:0] i);
    return {l[4:3], i[10:0]};
  endfunction
  task automatic chk(input string s, input logic [12:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One instruction cycle; checks the previous one once it has landed
  task automatic run(input logic [13:0] i, input int kd);
    instr_i <= i;
    tick <= lf[27];
    #1;
    case (pk)
      1: chk("file", 13'h0, 13'(mem.mem_q[qa]));
      2: chk("work", 13'h0, 13'(work));
      3: begin
        chk("wdt", 13'h0, 13'(wdt));
        chk("prescale", 13'h0, 13'(pre));
        chk("flags", 13'h3, 13'({tof, pdf}));
      end
      4: chk("skip", 13'(!qd[qb]), 13'(flush));
      5: begin
        chk("pc", pt, pc);
        chk("stack", ptos, stack_top);
        chk("flush", 13'h1, 13'(flush));
      end
      6: chk("ignored", 13'(qd), 13'(mem.mem_q[qa]));
      default: ;
    endcase
    if (pk == 1 || pk == 2) chk("zero", 13'h1, 13'(zero));
    pk = kd;
    qa = fa;
    qd = fd;
    qb = fb;
    if (kd == 1 || kd == 4 || kd == 6) mem.mem_q[fa] = fd;
    if (kd == 5) begin
      pt = call_pc(lat, i);
      ptos = epc + 13'h1;
      epc = pt;
    end else epc = epc + 13'h1;
    repeat (4) @(posedge clock_i);
  endtask
  initial forever #20 clock_i = ~clock_i;
  // Hang guard, well above the run length
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clock_i);
    resetn_i <= 1;
    // Corner cases: all don't-care bits set, skip on bit zero
    fa = 7'h7f;
    fd = 8'hfe;
    fb = 3'h0;
    run(CCIE_CLEAR_WORK_REG_OP_VAL | 14'h007f, 2);
    run(CCIE_BTSC_VAL | {4'h0, fb, fa}, 4);
    run(CCIE_CLEAR_FILE_REG_OP_VAL | {7'h00, fa}, 6);
    for (int n = 0; n < 90; n++) begin
      lf = nxt(lf);
      fa = lf[6:0];
      fd = lf[15:8];
      fb = lf[18:16];
      lat <= lf[23:19];
      k = fl ? 6 : 1 + int'(lf[26:24]) % 5;
      case (k)
        2: w = CCIE_CLEAR_WORK_REG_OP_VAL | {7'h00, lf[6:0]};
        3: w = CCIE_CLEAR_WATCHDOG_OP_VAL;
        4: w = CCIE_BTSC_VAL | {4'h0, fb, fa};
        5: w = CCIE_CALL_VAL | {3'h0, lf[10:0]};
        default: w = CCIE_CLEAR_FILE_REG_OP_VAL | {7'h00, fa};
      endcase
      run(w, k);
      fl = k == 5 || (k == 4 && !fd[fb]);
    end
    run(14'h0000, 0);
    close_out();
  end
endmodule
